// File: rtl/fdms_pkg.sv
// fdms_pkg: constants shared by the nonvolatile data memory sequencer.
// assumes a 100 MHz core clock and a core with 12 clocks per machine cycle.
package fdms_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned CLKS_PER_MC      = 12;
  localparam int unsigned RD_PAGE_MC       = 5;
  localparam int unsigned RD_BYTE_MC       = 3;
  localparam int unsigned T_WR_PAGE_US     = 380;
  localparam int unsigned T_WR_BYTE_US     = 200;
  localparam int unsigned T_ERASE_MS       = 2;
  localparam int unsigned T_PM_WR_PAGE_MS  = 15;
  localparam int unsigned RD_PAGE_CYC      = RD_PAGE_MC * CLKS_PER_MC;
  localparam int unsigned RD_BYTE_CYC      = RD_BYTE_MC * CLKS_PER_MC;
  localparam int unsigned WR_PAGE_CYC      = (T_WR_PAGE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WR_BYTE_CYC      = (T_WR_BYTE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC        = (T_ERASE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PM_WR_PAGE_CYC   = (T_PM_WR_PAGE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W            = 24;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int unsigned PAGE_BYTES       = 4;
  localparam int unsigned NUM_PAGES        = 1024;
  localparam int unsigned ARRAY_BYTES      = PAGE_BYTES * NUM_PAGES;
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;

  // ----------------------------------------------------------------
  // command codes written to memory_command_reg
  // ----------------------------------------------------------------
  localparam logic [7:0]  PAGE_READ_CMD             = 8'h01;
  localparam logic [7:0]  PAGE_WRITE_CMD            = 8'h02;
  localparam logic [7:0]  PAGE_VERIFY_CMD           = 8'h04;
  localparam logic [7:0]  PAGE_ERASE_CMD            = 8'h05;
  localparam logic [7:0]  ARRAY_ERASE_CMD           = 8'h06;
  localparam logic [7:0]  SINGLE_BYTE_READ_CMD      = 8'h81;
  localparam logic [7:0]  SINGLE_BYTE_WRITE_CMD     = 8'h82;
  localparam logic [7:0]  LEAVE_PROGRAM_MEMORY_MODE = 8'h0f;
  localparam logic [7:0]  PROGRAM_MEMORY_MODE       = 8'hf0;
  localparam logic [7:0]  VERIFY_OK                 = 8'h00;
  localparam logic [7:0]  VERIFY_FAIL               = 8'h01;
  localparam logic [7:0]  CMD_RESET                 = 8'h00;

  // ----------------------------------------------------------------
  // register select codes on the core-side write port
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_ADDR_HIGH = 3'h0;
  localparam logic [2:0]  SEL_ADDR_LOW  = 3'h1;
  localparam logic [2:0]  SEL_DATA_ONE  = 3'h2;
  localparam logic [2:0]  SEL_DATA_TWO  = 3'h3;
  localparam logic [2:0]  SEL_DATA_3    = 3'h4;
  localparam logic [2:0]  SEL_DATA_4    = 3'h5;
  localparam logic [2:0]  SEL_CMD       = 3'h6;

  typedef enum logic {
    FDMS_IDLE,
    FDMS_BUSY
  } fdms_state_t;

endpackage : fdms_pkg

// File: rtl/fdms_timer.sv
// fdms_timer: down counter that times one memory operation.
// assumes load_i is a one-cycle pulse; done_o pulses in the last counted cycle.
`timescale 1ns/1ps
module fdms_timer (
  // clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_n_i,
  // control
  input  wire logic                     load_i,
  input  wire logic [fdms_pkg::TMR_W-1:0] len_i,
  // status
  output logic                          done_o
);

  logic [fdms_pkg::TMR_W-1:0] cnt_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // a length of n keeps the caller busy for exactly n cycles after the load
  assign done_o = (cnt_q == {{(fdms_pkg::TMR_W-1){1'b0}}, 1'b1});

endmodule : fdms_timer

// File: rtl/fdms_data_array.sv
// fdms_data_array: the 4096-byte nonvolatile data array, 1024 pages of 4 bytes.
// assumes at most one operation strobe per cycle; contents are not reset.
`timescale 1ns/1ps
module fdms_data_array (
  // clock
  input  wire logic        sys_clk_i,
  // addressing
  input  wire logic [9:0]  page_i,
  input  wire logic [11:0] byte_addr_i,
  // operations
  input  wire logic        page_write_i,
  input  wire logic        page_erase_i,
  input  wire logic        array_erase_i,
  input  wire logic        byte_write_i,
  input  wire logic [31:0] wdata_i,
  // read data
  output logic      [31:0] page_rdata_o,
  output logic      [7:0]  byte_rdata_o
);

  logic [7:0] mem [0:fdms_pkg::ARRAY_BYTES-1];

  // programming only clears bits, so a byte that was not erased keeps stale zeros
  always_ff @(posedge sys_clk_i) begin
    if (array_erase_i) begin
      for (int i = 0; i < fdms_pkg::ARRAY_BYTES; i++) begin
        mem[i] <= fdms_pkg::ERASED_BYTE;
      end
    end else if (page_erase_i) begin
      for (int b = 0; b < fdms_pkg::PAGE_BYTES; b++) begin
        mem[{page_i, 2'(b)}] <= fdms_pkg::ERASED_BYTE;
      end
    end else if (page_write_i) begin
      for (int b = 0; b < fdms_pkg::PAGE_BYTES; b++) begin
        mem[{page_i, 2'(b)}] <= mem[{page_i, 2'(b)}] & wdata_i[8*b +: 8];
      end
    end else if (byte_write_i) begin
      mem[byte_addr_i] <= mem[byte_addr_i] & wdata_i[7:0];
    end
  end

  always_comb begin
    for (int b = 0; b < fdms_pkg::PAGE_BYTES; b++) begin
      page_rdata_o[8*b +: 8] = mem[{page_i, 2'(b)}];
    end
  end

  assign byte_rdata_o = mem[byte_addr_i];

  page_erase_a : assert property (@(posedge sys_clk_i)
    page_erase_i && !array_erase_i |=> page_rdata_o == {4{fdms_pkg::ERASED_BYTE}})
    else $error("erased page does not read all ones");

endmodule : fdms_data_array

// File: rtl/fdms_seq.sv
// fdms_seq: command sequencer for the nonvolatile data memory and program memory.
// assumes the core writes registers through a select/strobe port on sys_clk_i and
// honours core_stall_o; program memory itself sits outside and takes pm_* requests.
//
// Overview of operation
// - two address registers, high and low byte
// - command 01h reads page into data bytes
// - bytes program correctly only when erased
// - erase clears a whole page, never one byte
// - verify reads zero on match, nonzero otherwise
// - command 06h erases the whole data array
// - page read and verify take 5 machine cycles
// - single byte read takes 3 machine cycles
// - page write stalls the core 380 us
// - page erase and array erase take 2 ms
// - single byte write takes 200 us
// - program memory page write takes 15 ms
// - program memory erases take 2 ms
// - program memory byte write takes 200 us
// - operation starts on the command write itself
// - core idles until the operation completes
// - core services no interrupts while busy
// - timers keep counting while core stalls
// - 1024 pages of four bytes, page-addressed
// - 81h reads byte, 82h writes byte
// - f0h selects program memory, 0fh data memory
`timescale 1ns/1ps
module fdms_seq #(
  parameter int unsigned WR_PAGE_CYC    = fdms_pkg::WR_PAGE_CYC,
  parameter int unsigned WR_BYTE_CYC    = fdms_pkg::WR_BYTE_CYC,
  parameter int unsigned ERASE_CYC      = fdms_pkg::ERASE_CYC,
  parameter int unsigned PM_WR_PAGE_CYC = fdms_pkg::PM_WR_PAGE_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // core register write port
  input  wire logic        reg_wr_i,
  input  wire logic [2:0]  reg_sel_i,
  input  wire logic [7:0]  reg_wdata_i,
  // register contents toward the core
  output logic      [7:0]  page_addr_high_o,
  output logic      [7:0]  page_addr_low_o,
  output logic      [7:0]  page_data_byte_one_o,
  output logic      [7:0]  page_data_byte_two_o,
  output logic      [7:0]  page_data_byte_3_o,
  output logic      [7:0]  page_data_byte_4_o,
  output logic      [7:0]  memory_command_reg_o,
  output logic             program_memory_mode_o,
  // core control
  output logic             core_stall_o,
  output logic             irq_hold_o,
  // program memory requests
  output logic             pm_start_o,
  output logic      [7:0]  pm_cmd_o,
  output logic      [15:0] pm_addr_o,
  output logic      [7:0]  pm_wdata_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [fdms_pkg::TMR_W-1:0] cyc(input int unsigned n);
    cyc = fdms_pkg::TMR_W'(n);
  endfunction : cyc

  // timed length of a command; zero marks a code that starts no timed operation in that mode
  function automatic logic [fdms_pkg::TMR_W-1:0] op_len(input logic [7:0] cmd,
                                                         input logic       pm);
    op_len = '0;
    case (cmd)
      fdms_pkg::PAGE_READ_CMD:         op_len = pm ? '0 : cyc(fdms_pkg::RD_PAGE_CYC);
      fdms_pkg::PAGE_VERIFY_CMD:       op_len = pm ? '0 : cyc(fdms_pkg::RD_PAGE_CYC);
      fdms_pkg::SINGLE_BYTE_READ_CMD:  op_len = pm ? '0 : cyc(fdms_pkg::RD_BYTE_CYC);
      fdms_pkg::PAGE_WRITE_CMD:        op_len = pm ? cyc(PM_WR_PAGE_CYC) : cyc(WR_PAGE_CYC);
      fdms_pkg::PAGE_ERASE_CMD:        op_len = cyc(ERASE_CYC);
      fdms_pkg::ARRAY_ERASE_CMD:       op_len = cyc(ERASE_CYC);
      fdms_pkg::SINGLE_BYTE_WRITE_CMD: op_len = cyc(WR_BYTE_CYC);
      default:                         op_len = '0;
    endcase
  endfunction : op_len

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [7:0]                 addr_hi_q;
  logic [7:0]                 addr_lo_q;
  logic [3:0][7:0]            data_q;
  logic [7:0]                 cmd_q;
  logic                       pm_mode_q;
  logic                       stall_q;
  logic                       irq_hold_q;
  fdms_pkg::fdms_state_t      state_q;
  logic [fdms_pkg::TMR_W-1:0] len;
  logic                       cmd_wr;
  logic                       start;
  logic                       done;
  logic [15:0]                page_addr_pair;
  logic [31:0]                page_rdata;
  logic [7:0]                 byte_rdata;
  logic                       dm_go;

  assign page_addr_pair = {addr_hi_q, addr_lo_q};
  // the core is stalled while busy, so any write seen then is dropped
  assign cmd_wr = reg_wr_i && (reg_sel_i == fdms_pkg::SEL_CMD) && (state_q == fdms_pkg::FDMS_IDLE);
  assign len    = op_len(reg_wdata_i, pm_mode_q);
  assign start  = cmd_wr && (len != '0);
  assign dm_go  = start && !pm_mode_q;

  // ----------------------------------------------------------------
  // data array and timer
  // ----------------------------------------------------------------
  fdms_data_array u_array (
    .sys_clk_i     (sys_clk_i),
    .page_i        (page_addr_pair[9:0]),
    .byte_addr_i   (page_addr_pair[11:0]),
    .page_write_i  (dm_go && reg_wdata_i == fdms_pkg::PAGE_WRITE_CMD),
    .page_erase_i  (dm_go && reg_wdata_i == fdms_pkg::PAGE_ERASE_CMD),
    .array_erase_i (dm_go && reg_wdata_i == fdms_pkg::ARRAY_ERASE_CMD),
    .byte_write_i  (dm_go && reg_wdata_i == fdms_pkg::SINGLE_BYTE_WRITE_CMD),
    .wdata_i       (data_q),
    .page_rdata_o  (page_rdata),
    .byte_rdata_o  (byte_rdata)
  );

  fdms_timer u_timer (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .load_i    (start),
    .len_i     (len),
    .done_o    (done)
  );

  // ----------------------------------------------------------------
  // address registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_hi_q <= 8'h00;
      addr_lo_q <= 8'h00;
    end else if (reg_wr_i && state_q == fdms_pkg::FDMS_IDLE) begin
      if (reg_sel_i == fdms_pkg::SEL_ADDR_HIGH) begin
        addr_hi_q <= reg_wdata_i;
      end
      if (reg_sel_i == fdms_pkg::SEL_ADDR_LOW) begin
        addr_lo_q <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // page data byte registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q <= '0;
    end else if (dm_go && reg_wdata_i == fdms_pkg::PAGE_READ_CMD) begin
      data_q <= page_rdata;
    end else if (dm_go && reg_wdata_i == fdms_pkg::SINGLE_BYTE_READ_CMD) begin
      data_q[0] <= byte_rdata;
    end else if (reg_wr_i && state_q == fdms_pkg::FDMS_IDLE) begin
      case (reg_sel_i)
        fdms_pkg::SEL_DATA_ONE: data_q[0] <= reg_wdata_i;
        fdms_pkg::SEL_DATA_TWO: data_q[1] <= reg_wdata_i;
        fdms_pkg::SEL_DATA_3:   data_q[2] <= reg_wdata_i;
        fdms_pkg::SEL_DATA_4:   data_q[3] <= reg_wdata_i;
        default:                data_q    <= data_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command register and verify result
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_q <= fdms_pkg::CMD_RESET;
    end else if (dm_go && reg_wdata_i == fdms_pkg::PAGE_VERIFY_CMD) begin
      cmd_q <= (page_rdata == data_q) ? fdms_pkg::VERIFY_OK : fdms_pkg::VERIFY_FAIL;
    end else if (cmd_wr) begin
      cmd_q <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // memory mode select
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pm_mode_q <= 1'b0;
    end else if (cmd_wr && reg_wdata_i == fdms_pkg::PROGRAM_MEMORY_MODE) begin
      pm_mode_q <= 1'b1;
    end else if (cmd_wr && reg_wdata_i == fdms_pkg::LEAVE_PROGRAM_MEMORY_MODE) begin
      pm_mode_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer state and core stall
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= fdms_pkg::FDMS_IDLE;
    end else begin
      case (state_q)
        fdms_pkg::FDMS_IDLE: begin
          if (start) begin
            state_q <= fdms_pkg::FDMS_BUSY;
          end
        end
        fdms_pkg::FDMS_BUSY: begin
          if (done) begin
            state_q <= fdms_pkg::FDMS_IDLE;
          end
        end
        default: state_q <= fdms_pkg::FDMS_IDLE;
      endcase
    end
  end

  // only the core is held; the clock keeps running so timers count on
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stall_q    <= 1'b0;
      irq_hold_q <= 1'b0;
    end else if (start) begin
      stall_q    <= 1'b1;
      irq_hold_q <= 1'b1;
    end else if (done) begin
      stall_q    <= 1'b0;
      irq_hold_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // program memory requests
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pm_start_o <= 1'b0;
      pm_cmd_o   <= 8'h00;
      pm_addr_o  <= 16'h0000;
      pm_wdata_o <= 8'h00;
    end else begin
      pm_start_o <= start && pm_mode_q;
      if (start && pm_mode_q) begin
        pm_cmd_o   <= reg_wdata_i;
        pm_addr_o  <= page_addr_pair;
        pm_wdata_o <= data_q[0];
      end
    end
  end

  assign page_addr_high_o      = addr_hi_q;
  assign page_addr_low_o       = addr_lo_q;
  assign page_data_byte_one_o  = data_q[0];
  assign page_data_byte_two_o  = data_q[1];
  assign page_data_byte_3_o    = data_q[2];
  assign page_data_byte_4_o    = data_q[3];
  assign memory_command_reg_o  = cmd_q;
  assign program_memory_mode_o = pm_mode_q;
  assign core_stall_o          = stall_q;
  assign irq_hold_o            = irq_hold_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic [fdms_pkg::TMR_W-1:0] run_len_q;
  logic [7:0]                 run_cmd_q;
  logic                       run_pm_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_len_q <= '0;
      run_cmd_q <= 8'h00;
      run_pm_q  <= 1'b0;
    end else if (start) begin
      run_len_q <= '0;
      run_cmd_q <= reg_wdata_i;
      run_pm_q  <= pm_mode_q;
    end else if (stall_q) begin
      run_len_q <= run_len_q + 1'b1;
    end
  end

  sequence op_ends;
    $fell(stall_q);
  endsequence

  sequence cmd_issued(logic [7:0] c);
    start && reg_wdata_i == c && !pm_mode_q;
  endsequence

  stall_start_a : assert property (start |=> stall_q && irq_hold_q)
    else $error("stall not raised after command write");
  irq_hold_a : assert property (irq_hold_q == (state_q == fdms_pkg::FDMS_BUSY))
    else $error("interrupt hold differs from busy state");
  read_page_a : assert property (cmd_issued(fdms_pkg::PAGE_READ_CMD)
      |=> data_q == $past(page_rdata))
    else $error("page read did not load data bytes");
  read_time_a : assert property (op_ends ##0 (!run_pm_q
      && (run_cmd_q == fdms_pkg::PAGE_READ_CMD || run_cmd_q == fdms_pkg::PAGE_VERIFY_CMD))
      |-> run_len_q == cyc(fdms_pkg::RD_PAGE_CYC))
    else $error("page read or verify length wrong");
  byte_read_a : assert property (op_ends ##0 run_cmd_q == fdms_pkg::SINGLE_BYTE_READ_CMD
      |-> run_len_q == cyc(fdms_pkg::RD_BYTE_CYC))
    else $error("byte read length wrong");
  write_time_a : assert property (op_ends ##0 (!run_pm_q
      && run_cmd_q == fdms_pkg::PAGE_WRITE_CMD) |-> run_len_q == cyc(WR_PAGE_CYC))
    else $error("page write length wrong");
  erase_time_a : assert property (op_ends ##0 (run_cmd_q == fdms_pkg::PAGE_ERASE_CMD
      || run_cmd_q == fdms_pkg::ARRAY_ERASE_CMD) |-> run_len_q == cyc(ERASE_CYC))
    else $error("erase length wrong");
  byte_write_a : assert property (op_ends ##0 run_cmd_q == fdms_pkg::SINGLE_BYTE_WRITE_CMD
      |-> run_len_q == cyc(WR_BYTE_CYC))
    else $error("byte write length wrong");
  pm_write_a : assert property (op_ends ##0 (run_pm_q
      && run_cmd_q == fdms_pkg::PAGE_WRITE_CMD) |-> run_len_q == cyc(PM_WR_PAGE_CYC))
    else $error("program page write length wrong");
  verify_result_a : assert property (cmd_issued(fdms_pkg::PAGE_VERIFY_CMD)
      |=> (cmd_q == fdms_pkg::VERIFY_OK) == ($past(page_rdata) == $past(data_q)))
    else $error("verify result wrong");
  mode_switch_a : assert property (cmd_wr && reg_wdata_i == fdms_pkg::PROGRAM_MEMORY_MODE
      |=> pm_mode_q && !stall_q)
    else $error("program memory mode not entered");
  pm_request_a : assert property (start && pm_mode_q
      |=> pm_start_o && pm_cmd_o == $past(reg_wdata_i) && pm_addr_o == $past(page_addr_pair))
    else $error("program memory request not issued");
  stall_release_a : assert property (done && state_q == fdms_pkg::FDMS_BUSY
      |=> !stall_q && state_q == fdms_pkg::FDMS_IDLE)
    else $error("stall not released after completion");

endmodule : fdms_seq

// File: dv/fdms_core_model.sv
// fdms_core_model: core side that writes the sequencer's registers.
// assumes the sequencer stalls the core while a memory operation runs.
`timescale 1ns/1ps
module fdms_core_model (
  // clock and stall
  input  wire logic       sys_clk_i,
  input  wire logic       stall_i,
  // register write port
  output logic            reg_wr_o,
  output logic      [2:0] reg_sel_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_sel_o   = 3'h7;
    reg_wdata_o = 8'h00;
  end
  // a stalled core executes nothing, so a write waits out the stall
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(negedge sys_clk_i);
    while (stall_i !== 1'b0) @(negedge sys_clk_i);
    reg_wr_o    = 1'b1;
    reg_sel_o   = sel;
    reg_wdata_o = d;
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b0;
    reg_sel_o   = ~sel;
    // released lines must not keep the last value
    reg_wdata_o = ~d;
  endtask : wr
endmodule : fdms_core_model

// File: dv/flash_data_memory_sequencer_tb.sv
// flash_data_memory_sequencer_tb: self-checking bench for the sequencer.
// assumes shortened operation times set through the top's parameters.
`timescale 1ns/1ps
module flash_data_memory_sequencer_tb;
  logic        sys_clk_i, reset_n_i, reg_wr, stall, irq_hold, mode, pm_start;
  logic [2:0]  reg_sel;
  logic [7:0]  wd, ah, al, d1, d2, d3, d4, cmd_q, pm_cmd, pm_wdata;
  logic [15:0] pm_addr;
  int          err_total, checks, cyc;

  fdms_seq #(.WR_PAGE_CYC(40), .WR_BYTE_CYC(20), .ERASE_CYC(50), .PM_WR_PAGE_CYC(80)) dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr), .reg_sel_i(reg_sel),
    .reg_wdata_i(wd), .page_addr_high_o(ah), .page_addr_low_o(al),
    .page_data_byte_one_o(d1), .page_data_byte_two_o(d2), .page_data_byte_3_o(d3),
    .page_data_byte_4_o(d4), .memory_command_reg_o(cmd_q), .program_memory_mode_o(mode),
    .core_stall_o(stall), .irq_hold_o(irq_hold), .pm_start_o(pm_start), .pm_cmd_o(pm_cmd),
    .pm_addr_o(pm_addr), .pm_wdata_o(pm_wdata));
  fdms_core_model core (.sys_clk_i(sys_clk_i), .stall_i(stall), .reg_wr_o(reg_wr),
    .reg_sel_o(reg_sel), .reg_wdata_o(wd));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic ld(input logic [7:0] h, input logic [7:0] l, input logic [31:0] b);
    core.wr(fdms_pkg::SEL_ADDR_HIGH, h);
    core.wr(fdms_pkg::SEL_ADDR_LOW, l);
    core.wr(fdms_pkg::SEL_DATA_ONE, b[31:24]);
    core.wr(fdms_pkg::SEL_DATA_TWO, b[23:16]);
    core.wr(fdms_pkg::SEL_DATA_3, b[15:8]);
    core.wr(fdms_pkg::SEL_DATA_4, b[7:0]);
    check("address pair", {16'h0000, h, l}, {16'h0000, ah, al});
  endtask : ld
  // issues a command and measures how long the core stays stalled
  task automatic cmd(input logic [7:0] code, input int n);
    int k;
    k = 0;
    core.wr(fdms_pkg::SEL_CMD, code);
    if (n > 0 && mode === 1'b1) begin
      check("pm request", {24'h000001, code}, {23'h0, pm_start, pm_cmd});
    end
    while (stall === 1'b1 && k < 1000) begin
      if (irq_hold !== 1'b1) check("irq hold", 1, irq_hold);
      k++;
      @(negedge sys_clk_i);
    end
    check("stall cycles", n, k);
  endtask : cmd
  function automatic logic [31:0] page_q();
    return {d1, d2, d3, d4};
  endfunction : page_q

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_erase_all();
    ld(8'h00, 8'h03, 32'h0);
    cmd(fdms_pkg::ARRAY_ERASE_CMD, 50);
    cmd(fdms_pkg::PAGE_READ_CMD, 60);
    check("erased page", 32'hffffffff, page_q());
  endtask : t_erase_all
  task automatic t_write_verify();
    ld(8'h00, 8'h03, 32'h11f33344);
    cmd(fdms_pkg::PAGE_WRITE_CMD, 40);
    cmd(fdms_pkg::PAGE_VERIFY_CMD, 60);
    check("verify ok", 32'h0, {24'h0, cmd_q});
    core.wr(fdms_pkg::SEL_DATA_TWO, 8'h00);
    cmd(fdms_pkg::PAGE_VERIFY_CMD, 60);
    check("verify fail", 1, {31'h0, |cmd_q});
    cmd(fdms_pkg::PAGE_READ_CMD, 60);
    check("page read", 32'h11f33344, page_q());
  endtask : t_write_verify
  task automatic t_bytes();
    ld(8'h00, 8'h0d, 32'h0);
    cmd(fdms_pkg::SINGLE_BYTE_READ_CMD, 36);
    check("byte read", 32'hf3, {24'h0, d1});
    core.wr(fdms_pkg::SEL_DATA_ONE, 8'h0f);
    cmd(fdms_pkg::SINGLE_BYTE_WRITE_CMD, 20);
    cmd(fdms_pkg::SINGLE_BYTE_READ_CMD, 36);
    // byte was not erased, so only cleared bits take effect
    check("unerased write", 32'h03, {24'h0, d1});
    ld(8'h00, 8'h03, 32'h0);
    cmd(fdms_pkg::PAGE_ERASE_CMD, 50);
    cmd(fdms_pkg::PAGE_READ_CMD, 60);
    check("page erase", 32'hffffffff, page_q());
  endtask : t_bytes
  task automatic t_program_mode();
    cmd(fdms_pkg::PROGRAM_MEMORY_MODE, 0);
    check("mode on", 1, mode);
    ld(8'h12, 8'h34, 32'ha5000000);
    cmd(fdms_pkg::SINGLE_BYTE_WRITE_CMD, 20);
    check("pm addr data", 32'h1234a5, {8'h0, pm_addr, pm_wdata});
    cmd(fdms_pkg::PAGE_WRITE_CMD, 80);
    cmd(fdms_pkg::PAGE_ERASE_CMD, 50);
    cmd(fdms_pkg::ARRAY_ERASE_CMD, 50);
    cmd(fdms_pkg::PAGE_READ_CMD, 0);
    cmd(fdms_pkg::LEAVE_PROGRAM_MEMORY_MODE, 0);
    check("mode off", 0, mode);
  endtask : t_program_mode

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // the whole run needs about 850 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    reset_n_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    t_erase_all();
    t_write_verify();
    t_bytes();
    t_program_mode();
    end_sim();
  end
endmodule : flash_data_memory_sequencer_tb
